// file: inc/mem_port_pkg.sv
// Package with register map, field positions and encodings of the port B block.
package mem_port_pkg;

  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] RSTVAL_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  localparam int CTRL_FULL_RESET_BIT = 0;
  localparam int CTRL_HAS_RESET_BIT  = 1;
  localparam int CTRL_PRIO_SR_BIT    = 2;
  localparam int CTRL_OUTREG_BIT     = 3;
  localparam int CTRL_SOFT_EN_BIT    = 4;
  localparam int CTRL_IN_REGS_A_BIT  = 5;
  localparam int CTRL_OUT_REGS_B_BIT = 6;
  localparam int CTRL_INJ_LSB        = 7;
  localparam int CTRL_WIDTH          = 9;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;

  localparam int STATUS_ERR_BIT      = 0;
  localparam int STATUS_HOLD_LSB     = 1;

  localparam logic [1:0] HOLD_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    INJ_NONE   = 2'h0,
    INJ_SINGLE = 2'h1,
    INJ_DOUBLE = 2'h2,
    INJ_BOTH   = 2'h3
  } inject_sel_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

endpackage

// file: src/soft_encoder.sv
// Check-bit encoder with optional error injection for the write path.
`timescale 1ns/1ps
`default_nettype none
module soft_encoder
  import mem_port_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic [DATA_W-1:0] data,
  input  wire logic              enable,
  input  wire inject_sel_t       inject_sel,
  input  wire logic              inject_single,
  input  wire logic              inject_double,
  output logic      [DATA_W:0]   codeword
);

  logic allow_single;
  logic allow_double;
  logic [DATA_W-1:0] flip;

  always_comb begin
    allow_single = enable && inject_single &&
                   (inject_sel == INJ_SINGLE || inject_sel == INJ_BOTH);
    allow_double = enable && inject_double &&
                   (inject_sel == INJ_DOUBLE || inject_sel == INJ_BOTH);
    flip = '0;
    if (allow_double) begin
      flip[1:0] = 2'h3;
    end else if (allow_single) begin
      flip[0] = 1'b1;
    end
    // The check bit covers the clean word, so a single injected flip is visible; a double flip cancels out.
    codeword = {^data, data ^ flip};
  end

endmodule // soft_encoder
`default_nettype wire

// file: src/mem_port_b.sv
// Dual-port memory with configurable port B reset and soft check options.
// How it works
// - Full reset clears read latch and output register
// - Otherwise reset clears output register only
// - Output register built from general logic
// - Full reset holds reset value two cycles
// - Injection select: none, single, double, both
// - Optional one-stage input register before encoding
// - Reset behaviour only when reset input present
// - Priority option: reset versus enable wins
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mem_port_b
  import mem_port_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 4
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic      [1:0]        hresp,
  input  wire logic              port_a_we,
  input  wire logic [ADDR_W-1:0] port_a_addr,
  input  wire logic [DATA_W-1:0] port_a_din,
  input  wire logic              port_a_inject_single,
  input  wire logic              port_a_inject_double,
  input  wire logic              port_b_ram_enable,
  input  wire logic              port_b_outreg_clock_enable,
  input  wire logic              port_b_reset,
  input  wire logic [ADDR_W-1:0] port_b_addr,
  output logic      [DATA_W-1:0] port_b_dout
);

  localparam int DEPTH = 1 << ADDR_W;

  // Register file and bus slave state.
  logic [CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
  logic [DATA_W-1:0]     rstval_reg, rstval_next;
  logic                  err_reg, err_next;
  logic [7:0]            addr_reg, addr_next;
  logic                  wr_pend_reg, wr_pend_next;
  logic [31:0]           hrdata_reg, hrdata_next;

  // Write path state.
  logic                  a_we_reg, a_we_next;
  logic [ADDR_W-1:0]     a_addr_reg, a_addr_next;
  logic [DATA_W-1:0]     a_din_reg, a_din_next;
  logic                  a_sgl_reg, a_sgl_next;
  logic                  a_dbl_reg, a_dbl_next;
  logic [DATA_W:0]       mem_reg [DEPTH];

  // Read path state.
  logic [DATA_W:0]       latch_reg, latch_next;
  logic [DATA_W-1:0]     dout_reg, dout_next;
  logic [1:0]            hold_reg, hold_next;
  logic                  chk_reg, chk_next;

  logic                  full_reset, has_reset, prio_sr, outreg_on;
  logic                  soft_en, in_regs_a, out_regs_b;
  inject_sel_t           inject_sel;
  logic                  addr_phase, do_write;
  logic                  w_we, w_sgl, w_dbl;
  logic [ADDR_W-1:0]     w_addr;
  logic [DATA_W-1:0]     w_din;
  logic [DATA_W:0]       w_code;
  logic                  out_en, rst_req, rst_take;
  logic                  parity_bad;

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input logic [CTRL_WIDTH-1:0] c,
                                            input logic [DATA_W-1:0] r,
                                            input logic e,
                                            input logic [1:0] h);
    logic [31:0] w;
    w = '0;
    unique case (a)
      CTRL_OFFSET:   w[CTRL_WIDTH-1:0] = c;
      RSTVAL_OFFSET: w[DATA_W-1:0] = r;
      STATUS_OFFSET: begin
        w[STATUS_ERR_BIT] = e;
        w[STATUS_HOLD_LSB +: 2] = h;
      end
      default:       w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    full_reset = ctrl_reg[CTRL_FULL_RESET_BIT];
    has_reset  = ctrl_reg[CTRL_HAS_RESET_BIT];
    prio_sr    = ctrl_reg[CTRL_PRIO_SR_BIT];
    outreg_on  = ctrl_reg[CTRL_OUTREG_BIT];
    soft_en    = ctrl_reg[CTRL_SOFT_EN_BIT];
    in_regs_a  = ctrl_reg[CTRL_IN_REGS_A_BIT];
    out_regs_b = ctrl_reg[CTRL_OUT_REGS_B_BIT];
    inject_sel = inject_sel_t'(ctrl_reg[CTRL_INJ_LSB +: 2]);
  end

  // Bus slave: zero wait states, read data prepared at the address phase.
  always_comb begin
    addr_phase   = hsel && hready && (htrans == HTRANS_NONSEQ);
    do_write     = wr_pend_reg;
    ctrl_next    = ctrl_reg;
    rstval_next  = rstval_reg;
    addr_next    = addr_reg;
    wr_pend_next = 1'b0;
    hrdata_next  = hrdata_reg;
    if (do_write) begin
      if (addr_reg == CTRL_OFFSET) begin
        ctrl_next = hwdata[CTRL_WIDTH-1:0];
      end
      if (addr_reg == RSTVAL_OFFSET) begin
        rstval_next = hwdata[DATA_W-1:0];
      end
    end
    if (addr_phase) begin
      addr_next    = haddr;
      wr_pend_next = hwrite;
      if (!hwrite) begin
        hrdata_next = read_word(haddr, ctrl_reg, rstval_reg, err_reg,
                                hold_reg);
      end
    end
  end

  // Write path with optional input stage ahead of the encoder.
  always_comb begin
    a_we_next   = port_a_we;
    a_addr_next = port_a_addr;
    a_din_next  = port_a_din;
    a_sgl_next  = port_a_inject_single;
    a_dbl_next  = port_a_inject_double;
    if (soft_en && in_regs_a) begin
      w_we   = a_we_reg;
      w_addr = a_addr_reg;
      w_din  = a_din_reg;
      w_sgl  = a_sgl_reg;
      w_dbl  = a_dbl_reg;
    end else begin
      w_we   = port_a_we;
      w_addr = port_a_addr;
      w_din  = port_a_din;
      w_sgl  = port_a_inject_single;
      w_dbl  = port_a_inject_double;
    end
  end

  soft_encoder #(
    .DATA_W        (DATA_W)
  ) u_encoder (
    .data          (w_din),
    .enable        (soft_en),
    .inject_sel    (inject_sel),
    .inject_single (w_sgl),
    .inject_double (w_dbl),
    .codeword      (w_code)
  );

  // Port B read path. Reset arbitrates against the enable of the stage
  // that drives the pins: the output register when present, else the RAM.
  always_comb begin
    rst_req    = has_reset && port_b_reset;
    out_en     = outreg_on ? port_b_outreg_clock_enable
                           : port_b_ram_enable;
    rst_take   = rst_req && (prio_sr || out_en);
    latch_next = latch_reg;
    dout_next  = dout_reg;
    hold_next  = hold_reg;
    if (port_b_ram_enable) begin
      latch_next = mem_reg[port_b_addr];
    end
    if (outreg_on) begin
      if (port_b_outreg_clock_enable) begin
        dout_next = latch_reg[DATA_W-1:0];
      end
    end else if (port_b_ram_enable) begin
      dout_next = mem_reg[port_b_addr][DATA_W-1:0];
    end
    if (hold_reg != 2'h0) begin
      hold_next = hold_reg - 2'h1;
      dout_next = rstval_reg;
    end
    if (rst_take) begin
      dout_next = rstval_reg;
      if (full_reset) begin
        latch_next = {^rstval_reg, rstval_reg};
        hold_next  = HOLD_CYCLES - 2'h1;
      end
    end
  end

  // Check of the latched word, optionally delayed one stage.
  always_comb begin
    parity_bad = soft_en && (^latch_reg);
    chk_next   = parity_bad;
    err_next   = err_reg;
    if (do_write && addr_reg == STATUS_OFFSET && hwdata[STATUS_ERR_BIT]) begin
      err_next = 1'b0;
    end
    if (out_regs_b ? chk_reg : parity_bad) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg    <= CTRL_RESET;
      rstval_reg  <= '0;
      err_reg     <= 1'b0;
      addr_reg    <= '0;
      wr_pend_reg <= 1'b0;
      hrdata_reg  <= '0;
      a_we_reg    <= 1'b0;
      a_addr_reg  <= '0;
      a_din_reg   <= '0;
      a_sgl_reg   <= 1'b0;
      a_dbl_reg   <= 1'b0;
      latch_reg   <= '0;
      dout_reg    <= '0;
      hold_reg    <= 2'h0;
      chk_reg     <= 1'b0;
    end else if (ce) begin
      ctrl_reg    <= ctrl_next;
      rstval_reg  <= rstval_next;
      err_reg     <= err_next;
      addr_reg    <= addr_next;
      wr_pend_reg <= wr_pend_next;
      hrdata_reg  <= hrdata_next;
      a_we_reg    <= a_we_next;
      a_addr_reg  <= a_addr_next;
      a_din_reg   <= a_din_next;
      a_sgl_reg   <= a_sgl_next;
      a_dbl_reg   <= a_dbl_next;
      latch_reg   <= latch_next;
      dout_reg    <= dout_next;
      hold_reg    <= hold_next;
      chk_reg     <= chk_next;
    end
  end

  // Storage array; contents are undefined until written.
  always_ff @(posedge hclk) begin
    if (ce && w_we) begin
      mem_reg[w_addr] <= w_code;
    end
  end

  always_comb begin
    hrdata      = hrdata_reg;
    port_b_dout = dout_reg;
  end

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule // mem_port_b
`default_nettype wire

// file: test/port_b_monitor.sv
// Checker of port B reset behaviour and register bus answers.
`timescale 1ns/1ps
`default_nettype none
module port_b_monitor
  import mem_port_pkg::*;
#(parameter int DATA_W = 16) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              ce,
  input wire logic              hsel,
  input wire logic [7:0]        haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic [1:0]        hresp,
  input wire logic              port_b_ram_enable,
  input wire logic              port_b_outreg_clock_enable,
  input wire logic              port_b_reset,
  input wire logic [DATA_W-1:0] port_b_dout
);
  logic                  w_q;
  logic [7:0]            a_q;
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [DATA_W-1:0]     rv;
  logic                  rd;
  logic                  take;
  logic                  sel_en;
  // Shadow copies of the control and reset value registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q  <= 1'b0;
      a_q  <= 8'h00;
      ctrl <= CTRL_RESET;
      rv   <= '0;
    end else if (ce) begin
      w_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      a_q <= haddr;
      if (w_q && a_q == CTRL_OFFSET) ctrl <= hwdata[CTRL_WIDTH-1:0];
      if (w_q && a_q == RSTVAL_OFFSET) rv <= hwdata[DATA_W-1:0];
    end
  end
  assign rd = ce && hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  assign sel_en = ctrl[CTRL_OUTREG_BIT] ? port_b_outreg_clock_enable
                                        : port_b_ram_enable;
  assign take = ce && port_b_reset && ctrl[CTRL_HAS_RESET_BIT]
                && (ctrl[CTRL_PRIO_SR_BIT] || sel_en);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rst; take |=> port_b_dout == rv; endproperty
  a_rst: assert property (p_rst) else $error("reset value missing");
  property p_hold; take && ctrl[CTRL_FULL_RESET_BIT] |=> (port_b_dout == rv) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  property p_absent;
    ce && port_b_reset && !ctrl[CTRL_HAS_RESET_BIT] && !port_b_ram_enable
    && !port_b_outreg_clock_enable |=> $stable(port_b_dout);
  endproperty
  a_absent: assert property (p_absent) else $error("absent reset acted");
  property p_prio;
    ce && port_b_reset && ctrl[CTRL_HAS_RESET_BIT] && !ctrl[CTRL_PRIO_SR_BIT]
    && !sel_en |=> $stable(port_b_dout);
  endproperty
  a_prio: assert property (p_prio) else $error("reset beat enable");
  property p_unmapped; rd && haddr == 8'h0C |=> hrdata == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_ctrl_rd; rd && haddr == CTRL_OFFSET && !w_q |=> hrdata == 32'(ctrl);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  c_full: cover property (take && ctrl[CTRL_FULL_RESET_BIT]);
  c_part: cover property (take && !ctrl[CTRL_FULL_RESET_BIT]);
  c_unm: cover property (rd && haddr == 8'h0C);
endmodule // port_b_monitor
bind mem_port_b port_b_monitor #(.DATA_W(DATA_W)) mon (.*);
`default_nettype wire

// file: test/port_b_user.sv
// Model of the user logic that writes port A and reads port B.
`timescale 1ns/1ps
`default_nettype none
module port_b_user #(parameter int DATA_W = 16, parameter int ADDR_W = 4) (
  input  wire logic              hclk,
  output logic                   port_a_we,
  output logic      [ADDR_W-1:0] port_a_addr,
  output logic      [DATA_W-1:0] port_a_din,
  output logic                   port_a_inject_single,
  output logic                   port_a_inject_double,
  output logic                   port_b_ram_enable,
  output logic                   port_b_outreg_clock_enable,
  output logic                   port_b_reset,
  output logic      [ADDR_W-1:0] port_b_addr
);
  initial begin
    {port_a_we, port_a_inject_single, port_a_inject_double} = 3'h0;
    {port_b_ram_enable, port_b_outreg_clock_enable, port_b_reset} = 3'h0;
    port_a_addr = '0;
    port_a_din = '0;
    port_b_addr = '0;
  end
  // Released data lines show the inverse of the last value.
  task automatic write_a(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic s, input logic x);
    port_a_we <= 1'b1;
    port_a_addr <= a;
    port_a_din <= d;
    port_a_inject_single <= s;
    port_a_inject_double <= x;
    @(posedge hclk);
    port_a_we <= 1'b0;
    port_a_din <= ~d;
    port_a_inject_single <= 1'b0;
    port_a_inject_double <= 1'b0;
  endtask
  task automatic cyc_b(input logic [ADDR_W-1:0] a, input logic e,
      input logic r, input logic g);
    port_b_addr <= a;
    port_b_ram_enable <= e;
    port_b_reset <= r;
    port_b_outreg_clock_enable <= g;
    @(posedge hclk);
    port_b_addr <= ~a;
    {port_b_ram_enable, port_b_reset, port_b_outreg_clock_enable} <= 3'h0;
  endtask
endmodule // port_b_user
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench of the port B block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mem_port_pkg::*;
;
  logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout;
  logic [7:0]  haddr;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic        port_a_we, port_a_inject_single, port_a_inject_double;
  logic        port_b_ram_enable, port_b_outreg_clock_enable, port_b_reset;
  logic [3:0]  port_a_addr, port_b_addr;
  logic [15:0] port_a_din, port_b_dout, rv, d, d2, e16;
  int          fails, tests_run;
  int          cv[5] = '{0, 2, 2, 10, 10};
  int          en[5] = '{0, 0, 1, 0, 0};
  int          rg[5] = '{0, 0, 0, 0, 1};
  assign hready = hreadyout;
  mem_port_b dut (.*);
  port_b_user u (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkd(input string nm, input logic [15:0] e, input logic [15:0] g);
    chk(nm, {16'h0000, e}, {16'h0000, g});
  endtask
  // Expected stored word after a write that asks for injection.
  function automatic logic [15:0] inj(input logic [15:0] v, input int s,
                                      input logic dbl);
    if (dbl && s > 1) return v ^ 16'h0003;
    return (s % 2 == 1) ? v ^ 16'h0001 : v;
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    q = hrdata;
    #1;
    if (n >= 100) begin fails++; summarize(); end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, ~e);
    chk(nm, e, q);
  endtask
  task automatic wa(input logic [3:0] a, input logic [15:0] v, input logic s, x);
    u.write_a(a, v, s, x);
    #1;
  endtask
  task automatic b(input logic [3:0] a, input logic e, input logic r, input logic g);
    u.cyc_b(a, e, r, g);
    #1;
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    fails = 0;
    tests_run = 0;
    d = 16'($urandom(37));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    rdc("ctrl", CTRL_OFFSET, '0);
    rdc("rstval", RSTVAL_OFFSET, '0);
    rv = 16'($urandom);
    ahb(1'b1, RSTVAL_OFFSET, {d, rv});
    rdc("rstval", RSTVAL_OFFSET, {16'h0000, rv});
    ahb(1'b1, CTRL_OFFSET, '1);
    rdc("ctrl", CTRL_OFFSET, 32'h0000_01FF);
    ahb(1'b1, 8'h0C, '1);
    rdc("unmapped", 8'h0C, '0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      ahb(1'b1, CTRL_OFFSET, 32'(6 + i % 2 + 8 * (i / 2)));
      wa(4'h3, d, 1'b0, 1'b0);
      b(4'h3, 1'b1, 1'b0, 1'b0);
      b(4'h3, 1'b0, 1'b0, 1'b1);
      chkd("read", d, port_b_dout);
      b(4'h3, 1'b0, 1'b1, 1'b0);
      chkd("reset", rv, port_b_dout);
      b(4'h3, 1'(i < 2), 1'b0, 1'b0);
      chkd("hold", (i == 0) ? d : rv, port_b_dout);
      b(4'h3, 1'b0, 1'b0, 1'b1);
      chkd("latch", (i % 2 == 1) ? rv : d, port_b_dout);
    end
    $display("test reset modes done");
    for (int j = 0; j < 5; j++) begin
      ahb(1'b1, CTRL_OFFSET, 32'(cv[j]));
      b(4'h3, 1'b1, 1'b0, 1'b0);
      b(4'h3, 1'b0, 1'b0, 1'b1);
      b(4'h3, 1'(en[j]), 1'b1, 1'(rg[j]));
      chkd("priority", (j == 2 || j == 4) ? rv : d, port_b_dout);
    end
    $display("test priority done");
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, CTRL_OFFSET, 32'h0000_0010 | 32'(k) << CTRL_IN_REGS_A_BIT);
      d2 = 16'($urandom);
      wa(4'h5, d2, 1'b0, 1'b0);
      b(4'h0, 1'b0, 1'b0, 1'b0);
      d = 16'($urandom);
      wa(4'h5, d, 1'b0, 1'b0);
      b(4'h5, 1'b1, 1'b0, 1'b0);
      chkd("input stage", (k == 1) ? d2 : d, port_b_dout);
    end
    $display("test input stage done");
    for (int s = 0; s < 4; s++) begin
      ahb(1'b1, CTRL_OFFSET, 32'h0000_0010 | 32'(s) << CTRL_INJ_LSB);
      d = 16'($urandom);
      wa(4'h6, d, 1'b1, 1'b0);
      wa(4'h7, d, 1'b1, 1'b1);
      b(4'h6, 1'b1, 1'b0, 1'b0);
      chkd("single", inj(d, s, 1'b0), port_b_dout);
      e16 = inj(d, s, 1'b1);
      b(4'h7, 1'b1, 1'b0, 1'b0);
      chkd("double", e16, port_b_dout);
    end
    ce <= 1'b0;
    b(4'h6, 1'b1, 1'b0, 1'b0);
    chkd("freeze", e16, port_b_dout);
    ce <= 1'b1;
    // A single flip leaves the sticky error set; the last read word has a double flip that passes the check.
    rdc("status", STATUS_OFFSET, 32'h0000_0001);
    ahb(1'b1, STATUS_OFFSET, 32'h0000_0001);
    rdc("status clear", STATUS_OFFSET, 32'h0000_0000);
    $display("test injection done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
